// ### cpu_core_regs.vh
// Special register addresses, field positions and reset values for the CPU core registers
`ifndef CPU_CORE_REGS_VH
`define CPU_CORE_REGS_VH
`define ADDR_STATUS     8'hd0
`define ADDR_SP         8'h81
`define ADDR_PTR_LOW    8'h82
`define ADDR_PTR_HIGH   8'h83
`define ADDR_MULDIV     8'hf0
`define RESET_STATUS    8'h00
`define RESET_SP        8'h07
`define RESET_PTR_LOW   8'h00
`define RESET_PTR_HIGH  8'h00
`define RESET_MULDIV    8'h00
`define BIT_CARRY       7
`define BIT_HALF_CARRY  6
`define BIT_USER_ZERO   5
`define BIT_BANK_HIGH   4
`define BIT_BANK_LOW    3
`define BIT_OVERFLOW    2
`define BIT_USER_ONE    1
`define BIT_PARITY      0
`define BANK_STRIDE     8'h08
`endif

// ### parity_tree.v
// Even-parity generator over one byte
`timescale 1ns/1ps
module parity_tree (
	input  wire [7:0] DATA,
	output wire       ODD
);
	assign ODD = ^DATA;
endmodule

// ### cpu_core_status_pointer_regs.v
// Program status word, stack pointer, data pointer and multiply/divide helper
`timescale 1ns/1ps
`include "cpu_core_regs.vh"
// Functional notes
// - Parity flag tracks accumulator odd ones count
// - Status word at D0, bit addressable, resets zero
// - Helper register holds multiply/divide operand, else scratch
// - Stack pointer is eight bits wide
// - Push increments pointer before writing data
// - Stack reached indirectly anywhere in RAM
// - Stack pointer resets to 07, first push 08
// - Data pointer built from high and low bytes
// - Data pointer usable as word or bytes
module cpu_core_status_pointer_regs (
	input  wire        MCLK,
	input  wire        RST,
	input  wire [7:0]  ACCUMULATOR_REGISTER,
	input  wire        SFR_WR,
	input  wire [7:0]  SFR_ADDR,
	input  wire [7:0]  SFR_WDATA,
	output reg  [7:0]  SFR_RDATA,
	output wire        SFR_HIT,
	input  wire        BIT_WR,
	input  wire [2:0]  BIT_SEL,
	input  wire        BIT_VALUE,
	input  wire        FLAGS_WR,
	input  wire [3:0]  FLAGS_MASK,
	input  wire        CARRY_IN,
	input  wire        HALF_CARRY_IN,
	input  wire        OVERFLOW_IN,
	input  wire        MULDIV_WR,
	input  wire [7:0]  MULDIV_RESULT,
	input  wire        STACK_PUSH,
	input  wire        STACK_POP,
	input  wire [7:0]  STACK_DATA,
	output reg         RAM_WR,
	output reg  [7:0]  RAM_ADDR,
	output reg  [7:0]  RAM_WDATA,
	input  wire        POINTER_WORD_WR,
	input  wire [15:0] POINTER_WORD,
	input  wire        POINTER_INC,
	input  wire [2:0]  REG_INDEX,
	output wire [7:0]  WORK_REG_ADDR,
	output wire [7:0]  PROGRAM_STATUS_WORD,
	output wire [7:0]  STACK_POINTER,
	output wire [15:0] DATA_POINTER,
	output wire [7:0]  MULDIV_OPERAND
);
	reg  [7:0]  status;
	reg  [7:0]  next_status;
	reg  [7:0]  stack_ptr;
	reg  [7:0]  next_stack_ptr;
	reg  [7:0]  data_pointer_high;
	reg  [7:0]  data_pointer_low;
	reg  [7:0]  next_pointer_high;
	reg  [7:0]  next_pointer_low;
	reg  [7:0]  muldiv;
	reg  [7:0]  next_muldiv;
	wire        parity;
	wire        sel_status;
	wire        sel_stack;
	wire        sel_low;
	wire        sel_high;
	wire        sel_helper;
	wire        wr_status;
	wire        wr_stack;
	wire        wr_low;
	wire        wr_high;
	wire        wr_helper;
	wire [7:0]  stack_up;
	wire [7:0]  stack_down;
	wire [15:0] pointer_up;
	wire [1:0]  bank;

	parity_tree u_parity (
		.DATA (ACCUMULATOR_REGISTER),
		.ODD  (parity)
	);

	assign sel_status = (SFR_ADDR == `ADDR_STATUS);
	assign sel_stack  = (SFR_ADDR == `ADDR_SP);
	assign sel_low    = (SFR_ADDR == `ADDR_PTR_LOW);
	assign sel_high   = (SFR_ADDR == `ADDR_PTR_HIGH);
	assign sel_helper = (SFR_ADDR == `ADDR_MULDIV);
	assign SFR_HIT    = sel_status | sel_stack | sel_low | sel_high | sel_helper;

	// Unmapped addresses never reach a register
	assign wr_status = SFR_WR & sel_status;
	assign wr_stack  = SFR_WR & sel_stack;
	assign wr_low    = SFR_WR & sel_low;
	assign wr_high   = SFR_WR & sel_high;
	assign wr_helper = SFR_WR & sel_helper;

	// Pre-increment on push, post-decrement on pop
	assign stack_up   = stack_ptr + 8'h01;
	assign stack_down = stack_ptr - 8'h01;
	assign pointer_up = {data_pointer_high, data_pointer_low} + 16'h0001;

	// Parity is stored, so it lags an accumulator change by one cycle
	always @* begin
		next_status = status;
		if (wr_status) begin
			next_status = SFR_WDATA;
		end else if (BIT_WR) begin
			next_status[BIT_SEL] = BIT_VALUE;
		end else if (FLAGS_WR) begin
			if (FLAGS_MASK[0]) begin
				next_status[`BIT_CARRY] = CARRY_IN;
			end
			if (FLAGS_MASK[1]) begin
				next_status[`BIT_HALF_CARRY] = HALF_CARRY_IN;
			end
			if (FLAGS_MASK[2]) begin
				next_status[`BIT_OVERFLOW] = OVERFLOW_IN;
			end
		end
		// Software cannot hold parity; hardware always wins
		next_status[`BIT_PARITY] = parity;
	end

	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			status <= `RESET_STATUS;
		end else begin
			status <= next_status;
		end
	end

	// Push beats pop beats a direct write
	always @* begin
		next_stack_ptr = stack_ptr;
		if (STACK_PUSH) begin
			next_stack_ptr = stack_up;
		end else if (STACK_POP) begin
			next_stack_ptr = stack_down;
		end else if (wr_stack) begin
			next_stack_ptr = SFR_WDATA;
		end
	end

	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			stack_ptr <= `RESET_SP;
		end else begin
			stack_ptr <= next_stack_ptr;
		end
	end

	// RAM address is the incremented pointer, never the old one
	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			RAM_WR    <= 1'b0;
			RAM_ADDR  <= 8'h00;
			RAM_WDATA <= 8'h00;
		end else begin
			RAM_WR <= STACK_PUSH;
			if (STACK_PUSH) begin
				RAM_ADDR  <= stack_up;
				RAM_WDATA <= STACK_DATA;
			end
		end
	end

	// Word load beats increment beats byte writes
	always @* begin
		next_pointer_high = data_pointer_high;
		next_pointer_low  = data_pointer_low;
		if (POINTER_WORD_WR) begin
			{next_pointer_high, next_pointer_low} = POINTER_WORD;
		end else if (POINTER_INC) begin
			{next_pointer_high, next_pointer_low} = pointer_up;
		end else begin
			if (wr_high) begin
				next_pointer_high = SFR_WDATA;
			end
			if (wr_low) begin
				next_pointer_low = SFR_WDATA;
			end
		end
	end

	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			data_pointer_high <= `RESET_PTR_HIGH;
			data_pointer_low  <= `RESET_PTR_LOW;
		end else begin
			data_pointer_high <= next_pointer_high;
			data_pointer_low  <= next_pointer_low;
		end
	end

	always @* begin
		next_muldiv = muldiv;
		if (MULDIV_WR) begin
			next_muldiv = MULDIV_RESULT;
		end else if (wr_helper) begin
			next_muldiv = SFR_WDATA;
		end
	end

	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			muldiv <= `RESET_MULDIV;
		end else begin
			muldiv <= next_muldiv;
		end
	end

	// Reads are combinational; unmapped addresses read zero
	always @* begin
		case (1'b1)
			sel_status: SFR_RDATA = status;
			sel_stack:  SFR_RDATA = stack_ptr;
			sel_low:    SFR_RDATA = data_pointer_low;
			sel_high:   SFR_RDATA = data_pointer_high;
			sel_helper: SFR_RDATA = muldiv;
			default:    SFR_RDATA = 8'h00;
		endcase
	end

	assign bank = {status[`BIT_BANK_HIGH], status[`BIT_BANK_LOW]};
	assign WORK_REG_ADDR = {3'b000, bank, REG_INDEX};
	assign PROGRAM_STATUS_WORD = status;
	assign STACK_POINTER = stack_ptr;
	assign DATA_POINTER = {data_pointer_high, data_pointer_low};
	assign MULDIV_OPERAND = muldiv;
endmodule

// ### core_regs_sva.sv
// Checker for the core status and pointer registers
`timescale 1ns/1ps
module core_regs_checker (
	input logic MCLK,RST,RAM_WR,STACK_PUSH,POINTER_WORD_WR,MULDIV_WR,
	input logic [2:0] REG_INDEX,
	input logic [7:0] ACCUMULATOR_REGISTER,SFR_ADDR,SFR_RDATA,STACK_DATA,RAM_ADDR,RAM_WDATA,
	input logic [7:0] WORK_REG_ADDR,PROGRAM_STATUS_WORD,STACK_POINTER,MULDIV_RESULT,MULDIV_OPERAND,
	input logic [15:0] POINTER_WORD,DATA_POINTER
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	sequence s_pushed;
		RAM_WR && RAM_ADDR==STACK_POINTER && RAM_WDATA==$past(STACK_DATA)
		&& STACK_POINTER==$past(STACK_POINTER)+8'h01;
	endsequence
	chk_parity_lag: assert property (PROGRAM_STATUS_WORD[0]==$past(^ACCUMULATOR_REGISTER))
		else $error("parity flag");
	chk_reset_vals: assert property ($past(RST) |-> {PROGRAM_STATUS_WORD[7:1],STACK_POINTER}==15'h07)
		else $error("reset value");
	chk_push_order: assert property (STACK_PUSH |=> s_pushed)
		else $error("push");
	chk_ram_cause: assert property (RAM_WR |-> $past(STACK_PUSH))
		else $error("stray ram write");
	chk_bank_map: assert property (WORK_REG_ADDR=={3'h0,PROGRAM_STATUS_WORD[4:3],REG_INDEX})
		else $error("bank map");
	chk_pointer_word: assert property (POINTER_WORD_WR |=> DATA_POINTER==$past(POINTER_WORD))
		else $error("word write");
	chk_status_read: assert property (SFR_ADDR==8'hd0 |-> SFR_RDATA==PROGRAM_STATUS_WORD)
		else $error("status read");
	chk_helper_load: assert property (MULDIV_WR |=> MULDIV_OPERAND==$past(MULDIV_RESULT))
		else $error("helper load");
endmodule
bind cpu_core_status_pointer_regs core_regs_checker u_chk (.*);

// ### testbench.sv
// Self-checking bench for the core status and pointer registers
`timescale 1ns/1ps
module testbench;
	logic MCLK=0,RST=1,SFR_WR=0,BIT_WR=0,BIT_VALUE=0,FLAGS_WR=0,CARRY_IN=0,HALF_CARRY_IN=0;
	logic OVERFLOW_IN=0,MULDIV_WR=0,STACK_PUSH=0,STACK_POP=0,POINTER_WORD_WR=0,POINTER_INC=0;
	logic SFR_HIT,RAM_WR;
	logic [2:0] BIT_SEL=0,REG_INDEX=5;
	logic [3:0] FLAGS_MASK=0;
	logic [7:0] ACCUMULATOR_REGISTER=0,SFR_ADDR=0,SFR_WDATA=0,MULDIV_RESULT=0,STACK_DATA=0;
	logic [7:0] SFR_RDATA,RAM_ADDR,RAM_WDATA,WORK_REG_ADDR,STACK_POINTER,MULDIV_OPERAND;
	logic [7:0] PROGRAM_STATUS_WORD;
	logic [15:0] POINTER_WORD=0,DATA_POINTER;
	// Address, write data, read back; unmapped reads zero
	logic [23:0] rows[7]='{24'hd01818,24'hd0fffe,24'h813c3c,24'h82a5a5,24'h835a5a,
		24'hf07777,24'h901100};
	int num_errors=0,checks=0;
	cpu_core_status_pointer_regs u_dut (.*);
	always #10 MCLK=~MCLK;
	task automatic cmp(logic [15:0] seen,exp);
		checks++;
		if (seen!==exp) begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h",$time,seen,exp);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d",checks,num_errors);
		if (num_errors==0 && checks>0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge MCLK);
		RST<=0;
		#1 cmp({PROGRAM_STATUS_WORD,STACK_POINTER},16'h0007);
		cmp(DATA_POINTER,16'h0000);
		$display("reset done");
		// Back to back pushes: data changes between them
		@(posedge MCLK) {STACK_PUSH,STACK_DATA}<={1'b1,8'h55};
		@(posedge MCLK) STACK_DATA<=8'h66;
		#1 cmp({RAM_ADDR,RAM_WDATA},16'h0855);
		@(posedge MCLK) STACK_PUSH<=0;
		#1 cmp({RAM_ADDR,RAM_WDATA},16'h0966);
		cmp(RAM_WR,1'b1);
		$display("push done");
		foreach (rows[i]) begin
			@(posedge MCLK) {SFR_WR,SFR_ADDR,SFR_WDATA}<={1'b1,rows[i][23:8]};
			@(posedge MCLK) SFR_WR<=0;
			#1 cmp(SFR_RDATA,rows[i][7:0]);
			cmp(SFR_HIT,rows[i][23:16]!=8'h90);
		end
		cmp(DATA_POINTER,16'h5aa5);
		cmp(WORK_REG_ADDR,8'h1d);
		$display("registers done");
		@(posedge MCLK) begin
			ACCUMULATOR_REGISTER<=8'h07;
			{FLAGS_WR,FLAGS_MASK,CARRY_IN,OVERFLOW_IN}<={1'b1,4'h7,2'b11};
		end
		@(posedge MCLK) {FLAGS_WR,BIT_WR,BIT_SEL}<={1'b0,1'b1,3'h5};
		@(posedge MCLK) BIT_WR<=0;
		#1 cmp(PROGRAM_STATUS_WORD,8'h9f);
		$display("flags done");
		@(posedge MCLK) {MULDIV_WR,MULDIV_RESULT,POINTER_WORD_WR,POINTER_WORD}<={9'h1c3,17'h112ff};
		@(posedge MCLK) {MULDIV_WR,POINTER_WORD_WR,POINTER_INC,STACK_POP}<=4'h3;
		#1 cmp(MULDIV_OPERAND,8'hc3);
		@(posedge MCLK) {POINTER_INC,STACK_POP}<=2'h0;
		#1 cmp(DATA_POINTER,16'h1300);
		cmp(STACK_POINTER,8'h3b);
		$display("pointers done");
		tally_and_finish;
	end
endmodule
